// >>> acc_analog_model.sv
// Behavioural analog inputs and wakeup trigger source facing the converter control
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
	input  wire logic       clk_sys,
	input  wire logic [5:0] channel_route,
	input  wire logic       fire,
	output logic [7:0]      sar_value,
	output logic            wakeup_conv_trigger
);
	////////////////////////////////////////////////////////////////////////////////
	logic [2:0] hold_cnt = 3'h0; // Trigger level length
	initial sar_value = 8'h00;
	// Each routed input shows its own level; with nothing routed the value toggles
	always @(posedge clk_sys) begin
		sar_value <= ~sar_value;
		for (int i = 0; i < 6; i++) begin
			if (channel_route == (6'h01 << i)) sar_value <= 8'h3C + 8'(i * 17);
		end
		// A trigger request holds the line high for four cycles
		if (fire) hold_cnt <= 3'h4;
		else if (hold_cnt != 3'h0) hold_cnt <= hold_cnt - 3'h1;
	end
	assign wakeup_conv_trigger = (hold_cnt != 3'h0);
endmodule : acc_analog_model
`default_nettype wire

// >>> acc_axil_slave.sv
// AXI4-Lite register slave for the converter control
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"
module acc_axil_slave
	import acc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             wr_stb,
	output logic [3:0]       wr_idx,
	output logic [7:0]       wr_data,
	output logic             rd_stb,
	output logic [3:0]       rd_idx,
	input  wire logic [7:0]  rd_data,
	input  wire logic        rd_hit
);
	acc_bus_s bus_ff;   // Bus state
	acc_bus_s nxt_bus;  // Next bus state
	logic     wr_go;    // Write completes this cycle
	logic     wr_ok;    // Write address word aligned and inside the 16-register window
	logic     wstrb_lo_ff; // Low byte lane strobe of the taken write data

	// Address/data captured in any order; response after both
	always_comb begin
		nxt_bus = bus_ff;
		wr_go = bus_ff.aw_got && bus_ff.w_got && !bus_ff.bvalid;
		wr_ok = (bus_ff.awaddr[31:6] == 26'h0) && (bus_ff.awaddr[1:0] == 2'h0);
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_bus.aw_got = 1'b1;
			nxt_bus.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_bus.w_got = 1'b1;
			nxt_bus.wdata = s_axi_wdata;
		end
		if (wr_go) begin
			nxt_bus.bvalid = 1'b1;
			nxt_bus.bresp = wr_ok ? 2'h0 : 2'h2;
			nxt_bus.aw_got = 1'b0;
			nxt_bus.w_got = 1'b0;
		end
		if (bus_ff.bvalid && s_axi_bready) begin
			nxt_bus.bvalid = 1'b0;
		end
		// Read answered one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_bus.rvalid = 1'b1;
			nxt_bus.rdata = {24'h0, rd_data};
			nxt_bus.rresp = (rd_hit && s_axi_araddr[31:6] == 26'h0 && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
		end else if (bus_ff.rvalid && s_axi_rready) begin
			nxt_bus.rvalid = 1'b0;
		end
	end

	// Register the bus state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_ff <= '0;
		end else begin
			bus_ff <= nxt_bus;
		end
	end

	assign s_axi_awready = !bus_ff.aw_got && !bus_ff.bvalid;
	assign s_axi_wready  = !bus_ff.w_got && !bus_ff.bvalid;
	assign s_axi_bvalid  = bus_ff.bvalid;
	assign s_axi_bresp   = bus_ff.bresp;
	assign s_axi_arready = !bus_ff.rvalid;
	assign s_axi_rvalid  = bus_ff.rvalid;
	assign s_axi_rdata   = bus_ff.rdata;
	assign s_axi_rresp   = bus_ff.rresp;
	assign wr_stb  = wr_go && wr_ok && wstrb_lo_ff; // Only the low byte lane writes
	assign wr_idx  = bus_ff.awaddr[5:2];
	assign wr_data = bus_ff.wdata[7:0];
	assign rd_stb  = s_axi_arvalid && s_axi_arready;
	assign rd_idx  = s_axi_araddr[5:2];

	// Low byte lane strobe held with the write data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wstrb_lo_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wstrb_lo_ff <= s_axi_wstrb[0];
		end
	end
endmodule : acc_axil_slave
`default_nettype wire

// >>> acc_conv_ctrl.sv
// Top of the converter control: registers, sequencing and status
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"
module acc_conv_ctrl
	import acc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        stop_enter,
	input  wire logic        wakeup_conv_trigger,
	input  wire logic [7:0]  sar_value,
	output logic             sar_run,
	output logic             sample_hold,
	output logic             analog_input_disable,
	output logic [5:0]       channel_route,
	output logic             conv_irq
);
	acc_core_s   core_ff;    // Block state apart from the STOP synchroniser, done_prev_ff and the bus slave
	acc_core_s   nxt_core;   // Next block state
	logic        wr_stb;     // Register write strobe
	logic [3:0]  wr_idx;     // Written register index
	logic [7:0]  wr_data;    // Written byte
	logic        rd_stb;     // Register read strobe
	logic [3:0]  rd_idx;     // Read register index
	logic [7:0]  rd_data;    // Read byte
	logic        rd_hit;     // Read hits a register
	logic [10:0] conv_len;   // Cycles for the selected time
	logic        start_req;  // A start command this cycle
	logic        trig_edge;  // Rising trigger edge
	logic        finish;     // Conversion completes this cycle
	acc_mode_e   mode;       // Decoded mode
	logic        stop_sync_a; // STOP synchroniser stage 1
	logic        stop_sync_b; // STOP synchroniser stage 2

	////////////////////////////////////////////////////////////////////////////
	// Register bus slave
	acc_axil_slave u_bus (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.wr_stb        (wr_stb),
		.wr_idx        (wr_idx),
		.wr_data       (wr_data),
		.rd_stb        (rd_stb),
		.rd_idx        (rd_idx),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb begin
		rd_data = 8'h00;
		rd_hit  = 1'b1;
		case (rd_idx)
			`ACC_IDX_CTRL_A: rd_data = core_ff.ctrl_a;
			`ACC_IDX_CTRL_B: rd_data = core_ff.ctrl_b;
			`ACC_IDX_RESULT: rd_data = core_ff.result;
			`ACC_IDX_STATUS: begin
				rd_data[`ACC_DONE_BIT] = core_ff.done;
				rd_data[`ACC_BUSY_BIT] = core_ff.busy;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion time decode
	always_comb begin
		case (core_ff.ctrl_b[`ACC_TIME_HI:`ACC_TIME_LO])
			3'h3: conv_len = `ACC_CYC_156;
			3'h4: conv_len = `ACC_CYC_312;
			3'h5: conv_len = `ACC_CYC_624;
			3'h6: conv_len = `ACC_CYC_1248;
			default: conv_len = `ACC_CYC_1248; // Reserved codes take the longest time
		endcase
	end

	// Mode decode
	assign mode = acc_mode_e'(core_ff.ctrl_a[`ACC_MODE_HI:`ACC_MODE_LO]);

	////////////////////////////////////////////////////////////////////////////
	// STOP entry synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stop_sync_a <= 1'b0;
			stop_sync_b <= 1'b0;
		end else begin
			stop_sync_a <= stop_enter;
			stop_sync_b <= stop_sync_a;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencing, registers and flags
	always_comb begin
		nxt_core = core_ff;
		nxt_core.trig_sync = {core_ff.trig_sync[0], wakeup_conv_trigger};
		nxt_core.trig_prev = core_ff.trig_sync[1];
		trig_edge = core_ff.trig_sync[1] && !core_ff.trig_prev;
		finish = (core_ff.state == ACC_ST_CONV) && (core_ff.cnt == 11'd1);
		start_req = 1'b0;
		// Register writes
		if (wr_stb && wr_idx == `ACC_IDX_CTRL_A) begin
			nxt_core.ctrl_a = wr_data & 8'hF7;
			if (wr_data[`ACC_MODE_HI:`ACC_MODE_LO] == 2'h0) begin
				nxt_core.trig_used = 1'b0;
			end
			start_req = wr_data[`ACC_START_BIT] && (wr_data[`ACC_MODE_HI:`ACC_MODE_LO] == 2'h1);
		end
		if (wr_stb && wr_idx == `ACC_IDX_CTRL_B) begin
			nxt_core.ctrl_b = wr_data & 8'h1E;
		end
		// Hardware trigger start, first one only
		if (mode == ACC_MODE_TRIG && trig_edge && !core_ff.trig_used && !(wr_stb && wr_idx == `ACC_IDX_CTRL_A)) begin
			start_req = 1'b1;
			nxt_core.trig_used = 1'b1;
		end
		// Reading the result clears done unless it is being set now
		if (rd_stb && rd_idx == `ACC_IDX_RESULT) begin
			nxt_core.done = 1'b0;
		end
		// Counting down the conversion
		if (core_ff.state == ACC_ST_CONV) begin
			nxt_core.cnt = core_ff.cnt - 11'd1;
			if (finish) begin
				nxt_core.result = sar_value;
				nxt_core.done   = 1'b1;
				nxt_core.busy   = 1'b0;
				nxt_core.state  = ACC_ST_IDLE;
			end
		end
		// Start or restart, clears done and keeps the old result
		if (start_req) begin
			nxt_core.state = ACC_ST_CONV;
			nxt_core.cnt   = conv_len;
			nxt_core.busy  = 1'b1;
			nxt_core.done  = 1'b0;
			nxt_core.ctrl_a[`ACC_START_BIT] = 1'b0;
		end
		// Stop mode written halts at once, no result
		if (wr_stb && wr_idx == `ACC_IDX_CTRL_A && wr_data[`ACC_MODE_HI:`ACC_MODE_LO] == 2'h0) begin
			nxt_core.state = ACC_ST_IDLE;
			nxt_core.busy  = 1'b0;
			nxt_core.ctrl_a[`ACC_START_BIT] = 1'b0;
		end
		// STOP entry reinitialises the control registers
		if (stop_sync_b) begin
			nxt_core.ctrl_a    = `ACC_CTRL_A_RST;
			nxt_core.ctrl_b    = `ACC_CTRL_B_RST;
			nxt_core.state     = ACC_ST_IDLE;
			nxt_core.busy      = 1'b0;
			nxt_core.done      = 1'b0;
			nxt_core.trig_used = 1'b0;
		end
	end

	// State register on the system clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_ff <= '0;
		end else begin
			core_ff <= nxt_core;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog side outputs
	assign sar_run              = (core_ff.state == ACC_ST_CONV);
	assign sample_hold          = (core_ff.state == ACC_ST_CONV) && (core_ff.cnt == conv_len);
	assign analog_input_disable = core_ff.ctrl_a[`ACC_DIS_BIT];
	always_comb begin
		channel_route = 6'h00;
		if (!core_ff.ctrl_a[`ACC_DIS_BIT] && core_ff.ctrl_a[`ACC_CH_HI:`ACC_CH_LO] < 3'd6) begin
			channel_route[core_ff.ctrl_a[`ACC_CH_HI:`ACC_CH_LO]] = 1'b1;
		end
	end
	// One-cycle request as done rises
	logic done_prev_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_prev_ff <= 1'b0;
		end else begin
			done_prev_ff <= core_ff.done;
		end
	end
	assign conv_irq = core_ff.done && !done_prev_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Start launch
	AST_START_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start_req && !stop_sync_b |=> !core_ff.ctrl_a[`ACC_START_BIT] && core_ff.busy)
		else $error("start bit not cleared or busy low after start");
	// Restart reload
	AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start_req && !stop_sync_b |=> core_ff.cnt == $past(conv_len))
		else $error("restart did not reload count");
	// Length on launch
	AST_TIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(core_ff.busy) |-> core_ff.cnt == `ACC_CYC_156 || core_ff.cnt == `ACC_CYC_312
			|| core_ff.cnt == `ACC_CYC_624 || core_ff.cnt == `ACC_CYC_1248)
		else $error("bad conversion length");
	// Stop mode idles
	AST_STOP_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == ACC_MODE_STOP |-> !core_ff.busy)
		else $error("busy in stop mode");
	// End of conversion
	AST_END_TOGETHER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		finish && !start_req && !stop_sync_b |=> core_ff.done && core_ff.result == $past(sar_value) && !core_ff.busy)
		else $error("end of conversion not recorded together");
	// Result read
	AST_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_stb && rd_idx == `ACC_IDX_RESULT && !finish |=> !core_ff.done)
		else $error("done not cleared by result read");
	// Result held
	AST_RESULT_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!finish |=> core_ff.result == $past(core_ff.result))
		else $error("result changed outside end of conversion");
	// Request pulse
	AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(core_ff.done) |-> conv_irq ##1 !conv_irq)
		else $error("irq not a pulse on done");
	// STOP entry
	AST_STOP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stop_sync_b |=> core_ff.ctrl_a == `ACC_CTRL_A_RST && !core_ff.busy)
		else $error("STOP entry did not reset control");
	// Later triggers ignored; a register write may restart on its own
	AST_ONE_TRIG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		core_ff.trig_used && trig_edge && !stop_sync_b && !(wr_stb && wr_idx == `ACC_IDX_CTRL_A)
			|=> $stable(core_ff.cnt) || !core_ff.busy || core_ff.cnt == $past(core_ff.cnt) - 11'd1)
		else $error("second trigger accepted");
	// First trigger starts and is marked
	AST_TRIG_START: assert property (
		mode == ACC_MODE_TRIG && trig_edge && !core_ff.trig_used && !stop_sync_b
			&& !(wr_stb && wr_idx == `ACC_IDX_CTRL_A) |=> core_ff.busy && core_ff.trig_used)
		else $error("first trigger not taken");
	// Stop mode rearms the trigger
	AST_TRIG_CLEAR: assert property (
		wr_stb && wr_idx == `ACC_IDX_CTRL_A && wr_data[`ACC_MODE_HI:`ACC_MODE_LO] == 2'h0 |=> !core_ff.trig_used)
		else $error("trigger not rearmed");
	// Start bit low while a software conversion runs
	AST_START_LOW: assert property (
		core_ff.busy && mode == ACC_MODE_SOFT |-> !core_ff.ctrl_a[`ACC_START_BIT])
		else $error("start bit set during conversion");
	// Only the two start modes launch
	AST_MODE_START: assert property (
		$rose(core_ff.busy) |-> mode == ACC_MODE_SOFT || mode == ACC_MODE_TRIG)
		else $error("conversion launched in wrong mode");
	// Busy flag tracks the sequencer
	AST_BUSY_RUN: assert property (
		core_ff.busy == sar_run)
		else $error("busy and run disagree");
	// Count stays inside the longest time
	AST_CNT_RANGE: assert property (
		core_ff.busy |-> core_ff.cnt != 11'd0 && core_ff.cnt <= `ACC_CYC_1248)
		else $error("count out of range");
	// Done rises only at the end
	AST_DONE_AT_END: assert property (
		$rose(core_ff.done) |-> $past(finish))
		else $error("done rose without end");
	// Restart drops done
	AST_RESTART_DONE: assert property (
		start_req |=> !core_ff.done)
		else $error("done kept over restart");
	// Request only with done
	AST_IRQ_DONE: assert property (
		conv_irq |-> core_ff.done)
		else $error("irq without done");
	// STOP entry clears the rest
	AST_STOP_CLEARS: assert property (
		stop_sync_b |=> !core_ff.done && core_ff.ctrl_b == `ACC_CTRL_B_RST)
		else $error("STOP entry left state");
	// At most one input routed
	AST_ROUTE_ONEHOT: assert property (
		$onehot0(channel_route))
		else $error("several inputs routed");
	// Disable cuts every input
	AST_DIS_CUTS: assert property (
		analog_input_disable |-> channel_route == 6'h00)
		else $error("input routed while disabled");
	// Codes six and seven route nothing
	AST_CH_NONE: assert property (
		core_ff.ctrl_a[`ACC_CH_HI:`ACC_CH_LO] > 3'd5 |-> channel_route == 6'h00)
		else $error("unused code routed");
	// Code four routes input four
	AST_ROUTE_SEL: assert property (
		!analog_input_disable && core_ff.ctrl_a[`ACC_CH_HI:`ACC_CH_LO] == 3'd4 |-> channel_route == 6'h10)
		else $error("wrong input routed");
	COV_SOFT: cover property (@(posedge clk_sys) disable iff (!rst_n) mode == ACC_MODE_SOFT && finish);
	COV_TRIG: cover property (@(posedge clk_sys) disable iff (!rst_n) mode == ACC_MODE_TRIG && finish);
	COV_ABORT: cover property (@(posedge clk_sys) disable iff (!rst_n) core_ff.busy ##1 mode == ACC_MODE_STOP);
	COV_RESTART: cover property (@(posedge clk_sys) disable iff (!rst_n) core_ff.busy && start_req);
endmodule : acc_conv_ctrl
`default_nettype wire

// >>> acc_conv_ctrl_bench.sv
// Self-checking bench of the converter control
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"
module acc_conv_ctrl_bench
	import acc_pkg::*;
;
	////////////////////////////////////////////////////////////////////////////////
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        stop_enter = 1'b0, fire = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, sar_run, dis, irq, trig, sh;
	logic [1:0]  bresp, rresp;
	logic [7:0]  sar_value;
	logic [5:0]  route;
	int          n_mismatch = 0, checked = 0, cur = 0, last_len = 0, n_irq = 0, n_sh = 0;
	int          n_tab [4] = '{156, 312, 624, 1248}; // Conversion lengths per time code 3..6
	always #20 clk_sys = ~clk_sys;
	acc_conv_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .stop_enter(stop_enter),
		.wakeup_conv_trigger(trig), .sar_value(sar_value), .sar_run(sar_run), .sample_hold(sh),
		.analog_input_disable(dis), .channel_route(route), .conv_irq(irq));
	acc_analog_model far_side (.clk_sys(clk_sys), .channel_route(route), .fire(fire), .sar_value(sar_value),
		.wakeup_conv_trigger(trig));
	// Length of the last run, interrupt and sample pulses, taken where outputs are settled
	always @(negedge clk_sys) begin
		if (sar_run === 1'b1) cur <= cur + 1;
		else begin
			if (cur != 0) last_len <= cur;
			cur <= 0;
		end
		if (irq === 1'b1) n_irq <= n_irq + 1;
		if (sh === 1'b1) n_sh <= n_sh + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tmo();
		n_mismatch++;
		$display("[ERR] %0t wait ran out", $time);
		close_out();
	endtask : tmo
	// Bus write: address and data offered together, each released once taken
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic ta, tw, tb;
		logic [1:0] rs;
		@(posedge clk_sys);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= {26'h0, idx, 2'b00};
		wdata <= {24'h0, d};
		for (int i = 0; i < 50; i++) begin
			@(negedge clk_sys);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rs = bresp;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb === 1'b1) begin
				bready <= 1'b0;
				chk(32'(rs), 32'h0);
				return;
			end
		end
		tmo();
	endtask : wr
	// Bus read with expected response code
	task automatic rd(input logic [3:0] idx, output logic [7:0] d, input logic [1:0] er);
		logic ta, tb;
		logic [1:0] rs;
		@(posedge clk_sys);
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= {26'h0, idx, 2'b00};
		for (int i = 0; i < 50; i++) begin
			@(negedge clk_sys);
			ta = arvalid & arready;
			tb = rvalid;
			rs = rresp;
			d = rdata[7:0];
			@(posedge clk_sys);
			if (ta) arvalid <= 1'b0;
			if (tb === 1'b1) begin
				rready <= 1'b0;
				chk(32'(rs), 32'(er));
				return;
			end
		end
		tmo();
	endtask : rd
	function automatic logic [7:0] a_val(input logic st, input logic [1:0] md, input logic ds, input int ch);
		return {st, md, ds, 1'b0, 3'(ch)}; // Bit3 always zero
	endfunction : a_val
	function automatic logic [7:0] lvl(input int ch);
		return 8'h3C + 8'(ch * 17);
	endfunction : lvl
	task automatic wait_run(input logic v);
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk_sys);
			if (sar_run === v) return;
		end
		tmo();
	endtask : wait_run
	task automatic pulse_trig();
		@(posedge clk_sys);
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
	endtask : pulse_trig
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] d;
		rd(`ACC_IDX_CTRL_A, d, 2'h0);
		chk(32'(d), 32'(`ACC_CTRL_A_RST));
		rd(`ACC_IDX_CTRL_B, d, 2'h0);
		chk(32'(d), 32'(`ACC_CTRL_B_RST));
		rd(`ACC_IDX_RESULT, d, 2'h0);
		chk(32'(d), 32'(`ACC_RESULT_RST));
		rd(`ACC_IDX_STATUS, d, 2'h0);
		chk(32'(d[5:4]), 32'h0);
		rd(4'h7, d, 2'h2);
		chk(32'(d), 32'h0);
	endtask : t_reset
	task automatic t_times();
		logic [7:0] d;
		int i0;
		int s0;
		for (int k = 0; k < 4; k++) begin
			i0 = n_irq;
			s0 = n_sh;
			wr(`ACC_IDX_CTRL_B, {4'h0, 3'(k + 3), 1'b0}); // Legal time codes, fixed bits zero
			wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b01, 1'b0, k));
			rd(`ACC_IDX_STATUS, d, 2'h0);
			chk(32'(d[5:4]), 32'h1);
			rd(`ACC_IDX_CTRL_A, d, 2'h0);
			chk(32'(d), 32'(a_val(1'b0, 2'b01, 1'b0, k)));
			wait_run(1'b0);
			rd(`ACC_IDX_STATUS, d, 2'h0);
			chk(32'(d[5:4]), 32'h2);
			chk(32'(last_len), 32'(n_tab[k]));
			chk(32'(n_irq - i0), 32'h1);
			chk(32'(n_sh - s0), 32'h1);
			rd(`ACC_IDX_RESULT, d, 2'h0);
			chk(32'(d), 32'(lvl(k)));
			rd(`ACC_IDX_STATUS, d, 2'h0);
			chk(32'(d[5]), 32'h0);
		end
	endtask : t_times
	task automatic t_restart();
		logic [7:0] d;
		wr(`ACC_IDX_CTRL_B, 8'h06);
		wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b01, 1'b0, 0));
		wait_run(1'b0);
		wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b01, 1'b0, 1)); // Channel changed only while idle
		rd(`ACC_IDX_STATUS, d, 2'h0);
		chk(32'(d[5:4]), 32'h1);
		rd(`ACC_IDX_RESULT, d, 2'h0);
		chk(32'(d), 32'(lvl(0)));
		repeat (60) @(posedge clk_sys);
		wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b01, 1'b0, 1));
		wait_run(1'b0);
		rd(`ACC_IDX_RESULT, d, 2'h0);
		chk(32'(last_len > 156), 32'h1);
		chk(32'(d), 32'(lvl(1)));
	endtask : t_restart
	task automatic t_stopmode();
		logic [7:0] d;
		int i0;
		i0 = n_irq;
		wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b01, 1'b0, 2));
		repeat (20) @(posedge clk_sys);
		wr(`ACC_IDX_CTRL_A, a_val(1'b0, 2'b00, 1'b0, 2));
		chk(32'(sar_run), 32'h0);
		rd(`ACC_IDX_STATUS, d, 2'h0);
		chk(32'(d[5:4]), 32'h0);
		wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b00, 1'b0, 2));
		repeat (200) @(posedge clk_sys);
		chk(32'(n_irq - i0), 32'h0);
		rd(`ACC_IDX_RESULT, d, 2'h0);
		chk(32'(d), 32'(lvl(1)));
	endtask : t_stopmode
	task automatic t_trigger();
		logic [7:0] d;
		wr(`ACC_IDX_CTRL_A, a_val(1'b0, 2'b10, 1'b0, 3));
		pulse_trig();
		wait_run(1'b1);
		wait_run(1'b0);
		rd(`ACC_IDX_RESULT, d, 2'h0);
		chk(32'(d), 32'(lvl(3)));
		pulse_trig();
		repeat (12) @(posedge clk_sys);
		chk(32'(sar_run), 32'h0);
		wr(`ACC_IDX_CTRL_A, a_val(1'b0, 2'b00, 1'b0, 3));
		wr(`ACC_IDX_CTRL_A, a_val(1'b0, 2'b10, 1'b0, 3));
		pulse_trig();
		wait_run(1'b1);
		wait_run(1'b0);
	endtask : t_trigger
	task automatic t_route();
		for (int c = 0; c < 8; c++) begin
			for (int s = 0; s < 2; s++) begin
				wr(`ACC_IDX_CTRL_A, a_val(1'b0, 2'b00, 1'(s), c));
				chk(32'(dis), 32'(s));
				chk(32'(route), (s == 1 || c > 5) ? 32'h0 : 32'h1 << c);
			end
		end
	endtask : t_route
	task automatic t_stop();
		logic [7:0] d;
		wr(`ACC_IDX_CTRL_A, a_val(1'b1, 2'b01, 1'b0, 0));
		repeat (10) @(posedge clk_sys);
		stop_enter <= 1'b1;
		repeat (4) @(posedge clk_sys);
		stop_enter <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(32'(sar_run), 32'h0);
		rd(`ACC_IDX_CTRL_A, d, 2'h0);
		chk(32'(d), 32'h0);
		rd(`ACC_IDX_STATUS, d, 2'h0);
		chk(32'(d[5:4]), 32'h0);
	endtask : t_stop
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_times();
		t_restart();
		t_stopmode();
		t_trigger();
		t_route();
		t_stop();
		close_out();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		tmo();
	end
endmodule : acc_conv_ctrl_bench
`default_nettype wire

// >>> acc_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_IDX_CTRL_A      4'hE
`define ACC_IDX_CTRL_B      4'hF
`define ACC_IDX_RESULT      4'h0
`define ACC_IDX_STATUS      4'h1
`define ACC_IDX_POWER       4'h2
`define ACC_CTRL_A_RST      8'h00
`define ACC_CTRL_B_RST      8'h00
`define ACC_RESULT_RST      8'h00
`define ACC_START_BIT       7
`define ACC_MODE_HI         6
`define ACC_MODE_LO         5
`define ACC_DIS_BIT         4
`define ACC_CH_HI           2
`define ACC_CH_LO           0
`define ACC_TIME_HI         3
`define ACC_TIME_LO         1
`define ACC_DONE_BIT        5
`define ACC_BUSY_BIT        4
`define ACC_CYC_156         11'd156
`define ACC_CYC_312         11'd312
`define ACC_CYC_624         11'd624
`define ACC_CYC_1248        11'd1248
`define ACC_NUM_CH          6
`endif

// >>> acc_pkg.sv
// Types shared by the converter control files
package acc_pkg;
	typedef enum logic [1:0] {
		ACC_MODE_STOP,
		ACC_MODE_SOFT,
		ACC_MODE_TRIG,
		ACC_MODE_RSVD
	} acc_mode_e;
	typedef enum logic [1:0] {
		ACC_ST_IDLE,
		ACC_ST_CONV
	} acc_state_e;
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] result;
		logic       done;
		logic       busy;
		logic       trig_used;
		logic [10:0] cnt;
		acc_state_e state;
		logic [1:0] trig_sync;
		logic       trig_prev;
	} acc_core_s;
	typedef struct packed {
		logic        aw_got;
		logic [31:0] awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  bresp;
	} acc_bus_s;
endpackage : acc_pkg
